// ### rtl/hspq_pkg.sv
// Constants, register map and state types of the host serial port
// and its command queue.
// Assumes a 20 MHz core clock and a host-driven serial clock.
package hspq_pkg;

    // Lane-width codes
    localparam logic [1:0] WID_SINGLE = 2'h0;
    localparam logic [1:0] WID_DUAL = 2'h1;
    localparam logic [1:0] WID_QUAD = 2'h2;
    localparam logic [1:0] WID_RSVD = 2'h3;

    // Bits moved per serial clock edge in each width
    localparam logic [2:0] STEP_1 = 3'h1;
    localparam logic [2:0] STEP_2 = 3'h2;
    localparam logic [2:0] STEP_4 = 3'h4;

    // Command queue, 4 Kbyte at the bottom of the map
    localparam int QUEUE_BYTES = 4096;
    localparam int PTR_W = 12;
    localparam logic [14:0] ADR_QUEUE_END = 15'h0fff;
    localparam logic [14:0] ADR_WIDTH = 15'h1000;
    localparam logic [14:0] ADR_WRPTR_LO = 15'h1004;
    localparam logic [14:0] ADR_WRPTR_HI = 15'h1005;
    localparam logic [14:0] ADR_RDPTR_LO = 15'h1008;
    localparam logic [14:0] ADR_RDPTR_HI = 15'h1009;
    localparam logic [14:0] ADR_IRQ = 15'h100c;
    localparam logic [1:0] WIDTH_RESET = 2'h0;

    // Queue command layout: opcode, then 16-bit count, low byte first
    localparam logic [7:0] OP_TIMED_IRQ = 8'h01;
    localparam logic [11:0] CMD_STRIDE = 12'h004;
    localparam logic [11:0] CMD_MS_LO = 12'h001;
    localparam logic [11:0] CMD_MS_HI = 12'h002;

    // Byte position within a frame, saturating at the data phase
    localparam logic [1:0] FB_HDR_HI = 2'h0;
    localparam logic [1:0] FB_HDR_LO = 2'h1;
    localparam logic [1:0] FB_THIRD = 2'h2;
    localparam logic [1:0] FB_DATA = 2'h3;

    // Timer tick
    localparam int CLK_HZ = 20_000_000;
    localparam int TICK_MS = 1;
    localparam int MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

    typedef enum logic [1:0] {
        ENG_IDLE = 2'b01,
        ENG_RUN = 2'b10
    } hspq_eng_t;

    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] sh_in;
        logic [7:0] sh_out;
        logic [1:0] fidx;
        logic wr;
        logic [3:0] lo;
        logic [3:0] loe;
    } hspq_link_t;

    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic tg_s1;
        logic tg_s2;
        logic seen;
        logic [1:0] fidx;
        logic wr;
        logic [14:0] addr;
        logic [7:0] rd_byte;
        logic [1:0] width;
        logic [1:0] wpend;
        logic wpend_v;
        logic [7:0] wrlo;
        logic [PTR_W-1:0] wrptr;
        logic [PTR_W-1:0] rdptr;
        hspq_eng_t eng;
        logic tmr_on;
        logic [15:0] tmr_ms;
        logic [15:0] tmr_sub;
        logic irq;
        logic int_n;
        logic [1:0] gpo;
        logic [1:0] gpoe;
        logic [1:0] gi_s1;
        logic [1:0] gi_s2;
    } hspq_core_t;

endpackage : hspq_pkg

// ### rtl/hspq_port.sv
// Host serial slave port with lane-width select, command queue and
// queue engine with timed interrupt.
// Assumes the host drives link_sclk and link_cs_n; core runs on clk.
`timescale 1ns/10ps

module hspq_port
    import hspq_pkg::*;
#(
    parameter logic [15:0] MS_CYCLES = 16'(MS_CYCLES_DEF)
) (
    input wire logic clk,              // Core clock
    input wire logic rst_n,            // Reset, low; synchronous in the core, asynchronous for the link byte hand-off
    input wire logic ce,               // Core clock enable
    input wire logic link_sclk,        // Serial clock from host
    input wire logic link_cs_n,        // Chip select from host, low
    input wire logic [3:0] lane_i,     // Lane pin levels
    output logic [3:0] lane_o,         // Lane pin drive values
    output logic [3:0] lane_oe,        // Lane pin drive enables
    output logic int_n,                // Interrupt to host, low
    input wire logic [1:0] gpio_out,   // GPIO drive values
    input wire logic [1:0] gpio_oe,    // GPIO drive enables
    output logic [1:0] gpio_in         // GPIO pin levels
);

    hspq_link_t l_q, l_d;
    hspq_core_t c_q, c_d;
    logic [7:0] queue_mem [QUEUE_BYTES];
    logic [7:0] link_byte_q;
    logic link_tog_q;
    logic [2:0] step;
    logic [2:0] cnt_nx;
    logic [7:0] sh_in_nx;
    logic done;
    logic mem_we;
    logic [11:0] mem_wa;
    logic [7:0] mem_wd;
    logic [14:0] ra;
    logic [7:0] rv;
    logic ev;
    logic fire;
    logic clr;
    logic [7:0] eng_op;
    logic [15:0] eng_ms;

    // Link side: lanes sampled and driven on rising serial clock edges
    always_comb begin
        l_d = l_q;
        case (c_q.width)
            WID_DUAL: step = STEP_2;
            WID_QUAD: step = STEP_4;
            default: step = STEP_1;
        endcase
        case (c_q.width)
            WID_DUAL: sh_in_nx = {l_q.sh_in[5:0], lane_i[1:0]};
            WID_QUAD: sh_in_nx = {l_q.sh_in[3:0], lane_i};
            default: sh_in_nx = {l_q.sh_in[6:0], lane_i[0]};
        endcase
        cnt_nx = l_q.cnt + step;
        done = (cnt_nx == 3'h0);
        l_d.cnt = cnt_nx;
        l_d.sh_in = sh_in_nx;
        if (done) begin
            // Next byte comes from the core's prefetch
            l_d.sh_out = c_q.rd_byte;
            if (l_q.fidx == FB_HDR_HI) begin
                l_d.wr = sh_in_nx[7];
            end
            if (l_q.fidx != FB_DATA) begin
                l_d.fidx = l_q.fidx + 2'h1;
            end
        end else begin
            case (c_q.width)
                WID_DUAL: l_d.sh_out = {l_q.sh_out[5:0], 2'h0};
                WID_QUAD: l_d.sh_out = {l_q.sh_out[3:0], 4'h0};
                default: l_d.sh_out = {l_q.sh_out[6:0], 1'b0};
            endcase
        end
        case (c_q.width)
            WID_DUAL: begin
                l_d.lo = {2'h0, l_d.sh_out[7:6]};
                l_d.loe = (!l_d.wr && l_d.fidx == FB_DATA) ? 4'h3 : 4'h0;
            end
            WID_QUAD: begin
                l_d.lo = l_d.sh_out[7:4];
                l_d.loe = (!l_d.wr && l_d.fidx == FB_DATA) ? 4'hf : 4'h0;
            end
            default: begin
                // MISO driven from the first rising serial clock edge until deselect in single-lane mode
                l_d.lo = {2'h0, l_d.sh_out[7], 1'b0};
                l_d.loe = 4'h2;
            end
        endcase
    end

    // Frame state dies with chip select, so a short frame cannot leak
    always_ff @(posedge link_sclk or posedge link_cs_n) begin
        if (link_cs_n) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // Byte hand-off: toggle survives frames, cleared only by reset
    always_ff @(posedge link_sclk or negedge rst_n) begin
        if (!rst_n) begin
            link_tog_q <= 1'b0;
            link_byte_q <= 8'h00;
        end else if (!link_cs_n && done) begin
            link_tog_q <= ~link_tog_q;
            link_byte_q <= sh_in_nx;
        end
    end

    // Core side
    always_comb begin
        c_d = c_q;
        mem_we = 1'b0;
        mem_wa = c_q.addr[11:0];
        mem_wd = link_byte_q;
        fire = 1'b0;
        clr = 1'b0;
        ev = (c_q.tg_s2 != c_q.seen);
        ra = (c_q.fidx == FB_HDR_LO) ? {c_q.addr[14:8], link_byte_q}
                                     : c_q.addr;
        if (ra <= ADR_QUEUE_END) begin
            rv = queue_mem[ra[11:0]];
        end else begin
            case (ra)
                ADR_WIDTH: rv = {6'h00, c_q.width};
                ADR_WRPTR_LO: rv = c_q.wrptr[7:0];
                ADR_WRPTR_HI: rv = {4'h0, c_q.wrptr[11:8]};
                ADR_RDPTR_LO: rv = c_q.rdptr[7:0];
                ADR_RDPTR_HI: rv = {4'h0, c_q.rdptr[11:8]};
                ADR_IRQ: rv = {7'h00, c_q.irq};
                default: rv = 8'h00;
            endcase
        end
        eng_op = queue_mem[c_q.rdptr];
        eng_ms = {queue_mem[c_q.rdptr + CMD_MS_HI],
                  queue_mem[c_q.rdptr + CMD_MS_LO]};
        if (ce) begin
            c_d.cs_s1 = link_cs_n;
            c_d.cs_s2 = c_q.cs_s1;
            c_d.tg_s1 = link_tog_q;
            c_d.tg_s2 = c_q.tg_s1;
            c_d.gi_s1 = lane_i[3:2];
            c_d.gi_s2 = c_q.gi_s1;
            c_d.gpo = gpio_out;
            c_d.gpoe = gpio_oe;
            if (ev) begin
                c_d.seen = c_q.tg_s2;
                case (c_q.fidx)
                    FB_HDR_HI: begin
                        c_d.wr = link_byte_q[7];
                        c_d.addr = {link_byte_q[6:0], 8'h00};
                        c_d.fidx = FB_HDR_LO;
                    end
                    FB_HDR_LO: begin
                        c_d.addr = ra;
                        c_d.fidx = FB_THIRD;
                        if (!c_q.wr) begin
                            c_d.rd_byte = rv;
                            c_d.addr = ra + 15'h0001;
                            clr = (ra == ADR_IRQ);
                        end
                    end
                    default: begin
                        c_d.fidx = FB_DATA;
                        c_d.addr = c_q.addr + 15'h0001;
                        if (!c_q.wr) begin
                            c_d.rd_byte = rv;
                            clr = (ra == ADR_IRQ);
                        end else if (c_q.addr <= ADR_QUEUE_END) begin
                            mem_we = 1'b1;
                        end else begin
                            case (c_q.addr)
                                ADR_WIDTH: begin
                                    // Reserved code is dropped
                                    if (link_byte_q[1:0] != WID_RSVD) begin
                                        c_d.wpend = link_byte_q[1:0];
                                        c_d.wpend_v = 1'b1;
                                    end
                                end
                                ADR_WRPTR_LO: c_d.wrlo = link_byte_q;
                                ADR_WRPTR_HI: begin
                                    // Pointer moves as one on the high byte
                                    c_d.wrptr = {link_byte_q[3:0], c_q.wrlo};
                                end
                                default: c_d.wrlo = c_q.wrlo;
                            endcase
                        end
                    end
                endcase
            end else if (c_q.cs_s2) begin
                c_d.fidx = FB_HDR_HI;
                // Width only moves between frames
                if (c_q.wpend_v) begin
                    c_d.width = c_q.wpend;
                    c_d.wpend_v = 1'b0;
                end
            end
            case (c_q.eng)
                ENG_IDLE: begin
                    if (c_q.rdptr != c_q.wrptr) begin
                        c_d.eng = ENG_RUN;
                    end
                end
                ENG_RUN: begin
                    if (eng_op == OP_TIMED_IRQ) begin
                        c_d.tmr_on = (eng_ms != 16'h0000);
                        c_d.tmr_ms = eng_ms;
                        c_d.tmr_sub = 16'h0000;
                        fire = (eng_ms == 16'h0000);
                    end
                    // Wraps at the queue size by pointer width
                    c_d.rdptr = c_q.rdptr + CMD_STRIDE;
                    c_d.eng = ENG_IDLE;
                end
                default: c_d.eng = ENG_IDLE;
            endcase
            if (c_q.tmr_on) begin
                if (c_q.tmr_sub == MS_CYCLES - 16'h0001) begin
                    c_d.tmr_sub = 16'h0000;
                    c_d.tmr_ms = c_q.tmr_ms - 16'h0001;
                    if (c_q.tmr_ms == 16'h0001) begin
                        c_d.tmr_on = 1'b0;
                        fire = 1'b1;
                    end
                end else begin
                    c_d.tmr_sub = c_q.tmr_sub + 16'h0001;
                end
            end
            // A new timeout beats a read clearing the flag
            c_d.irq = fire | (c_q.irq & ~clr);
            c_d.int_n = ~c_d.irq;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            c_q <= '0;
            c_q.cs_s1 <= 1'b1;
            c_q.cs_s2 <= 1'b1;
            c_q.width <= WIDTH_RESET;
            c_q.eng <= ENG_IDLE;
            c_q.int_n <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    always_ff @(posedge clk) begin
        if (mem_we) begin
            queue_mem[mem_wa] <= mem_wd;
        end
    end

    // Lanes 2-3 belong to the GPIO pins unless quad mode is on
    always_comb begin
        lane_o[1:0] = l_q.lo[1:0];
        lane_oe[1:0] = l_q.loe[1:0];
        if (c_q.width == WID_QUAD) begin
            lane_o[3:2] = l_q.lo[3:2];
            lane_oe[3:2] = l_q.loe[3:2];
        end else begin
            lane_o[3:2] = c_q.gpo;
            lane_oe[3:2] = c_q.gpoe;
        end
    end

    assign int_n = c_q.int_n;
    assign gpio_in = c_q.gi_s2;

endmodule : hspq_port

// ### tb/hspq_props.sv
// Pin-level checks of the host serial port.
// Bound into hspq_port; sees its ports only.
`timescale 1ns/10ps
module hspq_props #(
    parameter logic [15:0] MS_CYCLES = 16'd20000
) (
    input logic clk,             // Core clock
    input logic rst_n,           // Reset, low
    input logic ce,              // Clock enable
    input logic link_sclk,       // Serial clock
    input logic link_cs_n,       // Select, low
    input logic [3:0] lane_i,    // Lane levels
    input logic [3:0] lane_o,    // Lane values
    input logic [3:0] lane_oe,   // Lane enables
    input logic int_n,           // Interrupt, low
    input logic [1:0] gpio_out,  // GPIO values
    input logic [1:0] gpio_oe,   // GPIO enables
    input logic [1:0] gpio_in    // GPIO levels
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    idle_release_a:
        assert property (link_cs_n |-> lane_oe[1:0] == 2'h0)
        else $error("lanes driven while deselected");
    reset_quiet_a:
        assert property ($rose(rst_n) |-> int_n)
        else $error("interrupt active after reset");
    irq_clear_a:
        assert property ($rose(int_n) |-> !link_cs_n)
        else $error("interrupt cleared outside a frame");
    irq_freeze_a:
        assert property (!ce |=> $stable(int_n) && $stable(gpio_in))
        else $error("state moved with enable low");
    sync_in_a:
        assert property ($past(ce) && $past(ce, 2) && $past(rst_n) &&
            $past(rst_n, 2) |-> gpio_in == $past(lane_i[3:2], 2))
        else $error("gpio input sync wrong");
    gpio_reg_a:
        assert property (link_cs_n && lane_oe[3:2] != 2'h0 && $past(ce)
            && $past(rst_n) |-> {lane_o[3:2], lane_oe[3:2]} ==
            $past({gpio_out, gpio_oe}))
        else $error("gpio drive not registered");
    lane_pair_a:
        assert property (lane_oe[0] |-> lane_oe[1])
        else $error("lane 0 driven alone");
    drive_frame_a:
        assert property ($rose(lane_oe[1]) |-> !link_cs_n)
        else $error("return lane driven outside frame");
endmodule : hspq_props

bind hspq_port hspq_props #(.MS_CYCLES(MS_CYCLES)) i_props (
    .clk(clk), .rst_n(rst_n), .ce(ce), .link_sclk(link_sclk),
    .link_cs_n(link_cs_n), .lane_i(lane_i), .lane_o(lane_o),
    .lane_oe(lane_oe), .int_n(int_n), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_in(gpio_in)
);

// ### tb/hspq_host.sv
// Host serial master model: clock, select and lane values.
// Assumes the bench resolves lanes, device drive winning.
`timescale 1ns/10ps
module hspq_host
    import hspq_pkg::*;
(
    output logic sclk,       // Serial clock, low between frames
    output logic cs_n,       // Select, low in a frame
    output logic [3:0] drv,  // Host lane values
    input logic [3:0] pin    // Resolved lane levels
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0;
        drv = 4'h0;
        // Late rise so the frame state's async clear sees an edge
        #10 cs_n = 1'b1;
    end
    task automatic shift(input logic [7:0] b, input int s, input bit rel,
                         output logic [7:0] got);
        logic [3:0] m;
        m = 4'((1 << s) - 1);
        got = 8'h00;
        for (int k = 0; k < 8; k += s) begin
            // Released lanes toggle so stale data cannot pass as read
            drv = rel ? ~drv : (4'(b >> (8 - s - k)) & m);
            #80; // 6.25 MHz, inside every mode's limit
            got = (got << s) | 8'((s == 1) ? pin[1] : pin & m);
            sclk = 1'b1;
            #80;
            sclk = 1'b0;
        end
    endtask : shift
    task automatic frame(input logic wr, input logic [14:0] a,
                         input logic [1:0] wid, input logic [7:0] wd,
                         output logic [7:0] rd);
        int s;
        logic [7:0] g;
        s = (wid == WID_QUAD) ? 4 : (wid == WID_DUAL) ? 2 : 1;
        rd = 8'h00;
        cs_n = 1'b0;
        #80;
        shift({wr, a[14:8]}, s, 1'b0, g);
        shift(a[7:0], s, 1'b0, g);
        shift(wd, s, !wr, g);
        if (!wr)
            shift(8'h00, s, 1'b1, rd);
        cs_n = 1'b1;
        drv = ~drv;
        #400;
    endtask : frame
endmodule : hspq_host

// ### tb/testbench.sv
// Self-checking bench of the host serial port and its queue.
// Core inputs change at falling clk; the host model owns the link.
`timescale 1ns/10ps
module testbench;
    import hspq_pkg::*;
    typedef struct packed {
        logic [14:0] adr;
        logic [7:0] wd;
        logic [7:0] exp;
    } hspq_row_t;
    logic clk, rst_n, ce, sclk, cs_n, int_n;
    logic [3:0] drv, pin, lane_o, lane_oe;
    logic [1:0] gpio_out, gpio_oe, gpio_in, wid;
    logic [7:0] got, lo;
    int err_total, num_checks, i;
    hspq_row_t rows [10] = '{
        '{15'h0000, 8'ha5, 8'ha5}, '{15'h0fff, 8'h3c, 8'h3c},
        '{ADR_WIDTH, 8'h01, 8'h01}, '{15'h0123, 8'h5a, 8'h5a},
        '{ADR_WIDTH, 8'h03, 8'h01}, '{ADR_WIDTH, 8'h02, 8'h02},
        '{15'h0abc, 8'hc3, 8'hc3}, '{ADR_RDPTR_LO, 8'hff, 8'h00},
        '{15'h1010, 8'h77, 8'h00}, '{ADR_WIDTH, 8'h00, 8'h00}};
    assign pin = (lane_oe & lane_o) | (~lane_oe & drv);
    hspq_port #(.MS_CYCLES(16'd20)) i_dut (.clk(clk), .rst_n(rst_n),
        .ce(ce), .link_sclk(sclk), .link_cs_n(cs_n), .lane_i(pin),
        .lane_o(lane_o), .lane_oe(lane_oe), .int_n(int_n),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in));
    hspq_host i_host (.sclk(sclk), .cs_n(cs_n), .drv(drv), .pin(pin));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [7:0] a, input logic [7:0] e);
        num_checks++;
        if (a !== e) begin
            err_total++;
            $display("CHECK FAILED %0t: got %h want %h", $time, a, e);
        end
    endtask : check
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        i_host.frame(1'b1, a, wid, d, got);
        if (a == ADR_WIDTH && d[1:0] != WID_RSVD)
            wid = d[1:0];
    endtask : wr
    task automatic rd(input logic [14:0] a, input logic [7:0] e);
        i_host.frame(1'b0, a, wid, 8'h00, got);
        check(got, e);
    endtask : rd
    task automatic do_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        wid = WID_SINGLE;
        repeat (4) @(negedge clk);
    endtask : do_reset
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        rst_n = 1'b1;
        // Fall after time zero so the async toggle clear sees an edge
        #1 rst_n = 1'b0;
        ce = 1'b1;
        gpio_out = 2'h0;
        gpio_oe = 2'h0;
        err_total = 0;
        num_checks = 0;
        do_reset();
        check({7'h0, int_n}, 8'h01);
        ce = 1'b0;
        repeat (3) @(negedge clk);
        ce = 1'b1;
        gpio_out = 2'h2;
        gpio_oe = 2'h3;
        repeat (4) @(negedge clk);
        check({4'h0, lane_o[3:2], gpio_in}, 8'h0a);
        rd(ADR_WIDTH, 8'h00);
        for (i = 0; i < 10; i++) begin
            wr(rows[i].adr, rows[i].wd);
            rd(rows[i].adr, rows[i].exp);
            if (wid == WID_QUAD)
                check({6'h0, lane_oe[3:2]}, 8'h00);
        end
        wr(15'h0ffc, OP_TIMED_IRQ);
        wr(15'h0ffd, 8'h02);
        wr(15'h0ffe, 8'h00);
        wr(15'h0fff, 8'h00);
        wr(ADR_WRPTR_LO, 8'hfc);
        wr(ADR_WRPTR_HI, 8'h0f);
        for (i = 0; i < 40; i++) begin
            i_host.frame(1'b0, ADR_RDPTR_LO, wid, 8'h00, lo);
            i_host.frame(1'b0, ADR_RDPTR_HI, wid, 8'h00, got);
            if ({got, lo} === 16'h0ffc)
                break;
        end
        check(got, 8'h0f);
        check(lo, 8'hfc);
        check({7'h0, int_n}, 8'h01);
        wr(ADR_WRPTR_LO, 8'h00);
        wr(ADR_WRPTR_HI, 8'h00);
        check({7'h0, int_n}, 8'h01);
        for (i = 0; i < 200 && int_n !== 1'b0; i++)
            @(negedge clk);
        if (i == 200) begin
            err_total++;
            report_and_stop();
        end
        check(8'(i > 15 && i < 60), 8'h01);
        rd(ADR_RDPTR_LO, 8'h00);
        rd(ADR_RDPTR_HI, 8'h00);
        rd(ADR_IRQ, 8'h01);
        check({7'h0, int_n}, 8'h01);
        rd(ADR_IRQ, 8'h00);
        wr(ADR_WIDTH, 8'h01);
        do_reset();
        rd(ADR_WIDTH, 8'h00);
        report_and_stop();
    end
endmodule : testbench
